// ---- core/nca_regs.svh ----
// Constants for the nibble core arithmetic and skip decoder
`ifndef NCA_REGS_SVH
`define NCA_REGS_SVH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define NCA_OP_HI 15
`define NCA_OP_LO 11
`define NCA_ROW_HI 10
`define NCA_ROW_LO 8
`define NCA_COL_HI 7
`define NCA_COL_LO 4
`define NCA_LOW_HI 3
`define NCA_LOW_LO 0
`define NCA_TGT_HI 10

// ----------------------------------------
// Program counter layout
// ----------------------------------------
`define NCA_PC_W 14
`define NCA_PC_SEG 13
`define NCA_PC_PAGE_HI 12
`define NCA_PC_PAGE_LO 11

// ----------------------------------------
// Op codes
// ----------------------------------------
`define NCA_OP_ADD_R 5'h00
`define NCA_OP_SUB_R 5'h01
`define NCA_OP_SUM_WITH_CARRY_OP_R 5'h02
`define NCA_OP_DIFFERENCE_WITH_BORROW_OP_R 5'h03
`define NCA_OP_AND_R 5'h04
`define NCA_OP_XOR_R 5'h05
`define NCA_OP_OR_R 5'h06
`define NCA_OP_MISC 5'h07
`define NCA_OP_SKE 5'h09
`define NCA_OP_SKIP_IF_UNEQUAL 5'h0b
`define NCA_OP_ADD_M 5'h10
`define NCA_OP_SUB_M 5'h11
`define NCA_OP_SUM_WITH_CARRY_OP_M 5'h12
`define NCA_OP_DIFFERENCE_WITH_BORROW_OP_M 5'h13
`define NCA_OP_AND_M 5'h14
`define NCA_OP_XOR_M 5'h15
`define NCA_OP_OR_M 5'h16
`define NCA_OP_SKT 5'h1e
`define NCA_OP_SKF 5'h1f

// ----------------------------------------
// Miscellaneous group sub-codes
// ----------------------------------------
`define NCA_SUB_INC_AR 4'h9
`define NCA_SUB_INC_IX 4'h8
`define NCA_ROW_ZERO 3'h0
`define NCA_LOW_ZERO 4'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define NCA_RST_NIB 4'h0
`define NCA_RST_SEG 1'h0

`endif

// ---- core/nca_pkg.sv ----
// Types for the nibble core arithmetic and skip decoder
package nca_pkg;

  // ----------------------------------------
  // ALU function, taken from op code bits 2..0
  // ----------------------------------------
  typedef enum logic [2:0] {
    NCA_FN_ADD = 3'h0,
    NCA_FN_SUB = 3'h1,
    NCA_FN_SUM_WITH_CARRY_OP = 3'h2,
    NCA_FN_DIFFERENCE_WITH_BORROW_OP = 3'h3,
    NCA_FN_AND = 3'h4,
    NCA_FN_XOR = 3'h5,
    NCA_FN_OR = 3'h6,
    NCA_FN_NONE = 3'h7
  } nca_fn_t;

  // ----------------------------------------
  // Execution state, Gray coded
  // ----------------------------------------
  typedef enum logic [1:0] {
    NCA_ST_RUN = 2'h0,
    NCA_ST_SKIP = 2'h1
  } nca_state_t;

endpackage

// ---- core/nca_alu.sv ----
// Four-bit ALU for the nibble core
`timescale 1ns/1ps
`include "nca_regs.svh"

module nca_alu
  import nca_pkg::*;
(
  input wire logic [3:0] a_i,
  input wire logic [3:0] b_i,
  input wire logic carry_i,
  input wire nca_fn_t fn_i,
  output logic [3:0] result_o,
  output logic carry_o,
  output logic zero_o
);

  logic [4:0] sum;
  logic [4:0] diff;
  logic cin;

  // Carry only enters the with-carry forms
  assign cin = (fn_i == NCA_FN_SUM_WITH_CARRY_OP || fn_i == NCA_FN_DIFFERENCE_WITH_BORROW_OP) ? carry_i : 1'h0;
  assign sum = {1'h0, a_i} + {1'h0, b_i} + {4'h0, cin};
  assign diff = {1'h0, a_i} - {1'h0, b_i} - {4'h0, cin};

  always_comb begin
    result_o = 4'h0;
    carry_o = 1'h0;
    case (fn_i)
      NCA_FN_ADD, NCA_FN_SUM_WITH_CARRY_OP: begin
        result_o = sum[3:0];
        carry_o = sum[4];
      end
      NCA_FN_SUB, NCA_FN_DIFFERENCE_WITH_BORROW_OP: begin
        result_o = diff[3:0];
        carry_o = diff[4];
      end
      NCA_FN_AND: result_o = a_i & b_i;
      NCA_FN_XOR: result_o = a_i ^ b_i;
      NCA_FN_OR: result_o = a_i | b_i;
      default: result_o = 4'h0;
    endcase
  end

  assign zero_o = (result_o == 4'h0);

endmodule

// ---- core/nca_exec.sv ----
// Execution unit for arithmetic, logic, increment and skip instructions
//
// Overview of operation
// [RQ1] Add memory to register, or immediate to memory
// [RQ2] Add with carry, both destination forms
// [RQ3] Subtract memory from register, or immediate from memory
// [RQ4] Subtract with borrow, both destination forms
// [RQ5] Inclusive or, register and memory forms
// [RQ6] Conjunction, register and memory forms
// [RQ7] Exclusive or, register and memory forms
// [RQ8] Increment address pointer on its sub-code
// [RQ9] Increment index register on its sub-code
// [RQ10] Bits-set test clears compare, skips if all set
// [RQ11] Bits-clear test clears compare, skips if all clear
// [RQ12] Skip when memory equals immediate, nothing stored
// [RQ13] Skip when memory differs from immediate
// [RQ14] Program counter bits 12..11 are the page
// [RQ15] One-bit segment register is program counter bit 13
// [RQ16] Branch target is low eleven address bits
// [RQ17] System call entry splits bits 10..8, 3..0
// [RQ18] Peripheral address: high 3, low 4 bits
// [RQ19] Register file address: row 3, column 4
// [RQ20] Interrupt pushes saved state onto stack
// [RQ21] Stack accessed at entry the stack index selects
// [RQ22] Skipped instruction fetched but acts as no-operation
`timescale 1ns/1ps
`include "nca_regs.svh"

module nca_exec
  import nca_pkg::*;
#(
  parameter int AR_W = 16,
  parameter int IX_W = 12,
  parameter int STK_W = 16,
  parameter int STK_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] reg_rdata_i,
  input wire logic [3:0] mem_rdata_i,
  input wire logic compare_set_i,
  input wire logic [`NCA_PC_W-1:0] pc_i,
  input wire logic segment_load_i,
  input wire logic segment_data_i,
  input wire logic irq_take_i,
  input wire logic [STK_W-1:0] auto_saved_state_i,
  input wire logic push_i,
  input wire logic [STK_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic reg_wr_o,
  output logic [3:0] reg_col_o,
  output logic [3:0] reg_wdata_o,
  output logic mem_wr_o,
  output logic [2:0] mem_row_o,
  output logic [3:0] mem_col_field_o,
  output logic [3:0] mem_wdata_o,
  output logic skip_o,
  output logic nop_o,
  output logic carry_flag_o,
  output logic compare_flag_o,
  output logic [AR_W-1:0] address_pointer_reg_o,
  output logic [IX_W-1:0] index_reg_o,
  output logic [1:0] page_o,
  output logic segment_bit_o,
  output logic [`NCA_PC_W-1:0] program_counter_o,
  output logic [10:0] branch_target_o,
  output logic [2:0] entry_hi_o,
  output logic [3:0] entry_lo_o,
  output logic [2:0] periph_hi_o,
  output logic [3:0] periph_lo_o,
  output logic [2:0] regfile_row_o,
  output logic [3:0] regfile_col_o,
  output logic [STK_W-1:0] stack_top_entry_o,
  output logic [$clog2(STK_DEPTH)-1:0] stack_index_o
);

  localparam int SP_W = $clog2(STK_DEPTH);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (AR_W < 1 || IX_W < 1 || STK_W < 1) begin : g_bad_width
    $error("nca_exec: widths must be at least one bit");
  end
  if (STK_DEPTH < 2 || (STK_DEPTH & (STK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("nca_exec: stack depth must be a power of two, at least 2");
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [4:0] opcode;
  logic [2:0] row_f;
  logic [3:0] col_f;
  logic [3:0] low_f;
  logic is_reg_form;
  logic is_mem_form;
  logic is_alu;
  logic is_arith;
  logic is_inc_ar;
  logic is_inc_ix;
  logic is_skt;
  logic is_skf;
  logic is_ske;
  logic is_skip_if_unequal;
  logic is_misc_plain;
  nca_state_t state;
  nca_state_t next_state;
  logic exec;
  logic squash;

  assign opcode = instr_i[`NCA_OP_HI:`NCA_OP_LO];
  assign row_f = instr_i[`NCA_ROW_HI:`NCA_ROW_LO];
  assign col_f = instr_i[`NCA_COL_HI:`NCA_COL_LO];
  assign low_f = instr_i[`NCA_LOW_HI:`NCA_LOW_LO];

  // A skipped slot still consumes its instruction
  assign exec = instr_valid_i && (state == NCA_ST_RUN);
  assign squash = instr_valid_i && (state == NCA_ST_SKIP); // RQ22

  assign is_reg_form = (opcode[4:3] == 2'h0) && (opcode[2:0] != 3'h7);
  assign is_mem_form = (opcode[4:3] == 2'h2) && (opcode[2:0] != 3'h7);
  assign is_alu = is_reg_form || is_mem_form;
  assign is_arith = is_alu && !opcode[2];
  assign is_misc_plain = (opcode == `NCA_OP_MISC) && (row_f == `NCA_ROW_ZERO)
                         && (low_f == `NCA_LOW_ZERO);
  assign is_inc_ar = is_misc_plain && (col_f == `NCA_SUB_INC_AR); // RQ8
  assign is_inc_ix = is_misc_plain && (col_f == `NCA_SUB_INC_IX); // RQ9
  assign is_skt = (opcode == `NCA_OP_SKT);
  assign is_skf = (opcode == `NCA_OP_SKF);
  assign is_ske = (opcode == `NCA_OP_SKE);
  assign is_skip_if_unequal = (opcode == `NCA_OP_SKIP_IF_UNEQUAL);

  // ----------------------------------------
  // Operand selection and ALU
  // ----------------------------------------
  logic [3:0] alu_a;
  logic [3:0] alu_b;
  nca_fn_t alu_fn;
  logic [3:0] alu_res;
  logic alu_cout;
  logic alu_zero;
  logic cmp_sel;
  logic carry_flag;

  // Compares subtract the immediate from memory without carry
  assign cmp_sel = is_ske || is_skip_if_unequal;
  assign alu_a = is_reg_form ? reg_rdata_i : mem_rdata_i;
  assign alu_b = is_reg_form ? mem_rdata_i : low_f;
  assign alu_fn = is_alu ? nca_fn_t'(opcode[2:0]) :
                  (cmp_sel ? NCA_FN_SUB : NCA_FN_NONE);

  nca_alu u_alu (
    .a_i(alu_a),
    .b_i(alu_b),
    .carry_i(carry_flag),
    .fn_i(alu_fn),
    .result_o(alu_res),
    .carry_o(alu_cout),
    .zero_o(alu_zero)
  );

  // ----------------------------------------
  // Skip conditions
  // ----------------------------------------
  logic bits_set;
  logic bits_clear;
  logic skip_hit;

  assign bits_set = ((mem_rdata_i & low_f) == low_f); // RQ10
  assign bits_clear = ((mem_rdata_i & low_f) == 4'h0); // RQ11
  assign skip_hit = exec && ((is_skt && bits_set) || (is_skf && bits_clear) // RQ10 RQ11
                    || (is_ske && alu_zero) || (is_skip_if_unequal && !alu_zero)); // RQ12 RQ13

  always_comb begin
    next_state = state;
    case (state)
      NCA_ST_RUN: if (skip_hit) begin
        next_state = NCA_ST_SKIP;
      end
      NCA_ST_SKIP: if (instr_valid_i) begin
        next_state = NCA_ST_RUN; // RQ22
      end
      default: next_state = NCA_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= NCA_ST_RUN;
      skip_o <= 1'h0;
      nop_o <= 1'h0;
    end else begin
      state <= next_state;
      skip_o <= skip_hit;
      nop_o <= squash;
    end
  end

  // ----------------------------------------
  // Register and memory write-back
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_wr_o <= 1'h0;
      mem_wr_o <= 1'h0;
      reg_col_o <= `NCA_RST_NIB;
      reg_wdata_o <= `NCA_RST_NIB;
      mem_row_o <= 3'h0;
      mem_col_field_o <= `NCA_RST_NIB;
      mem_wdata_o <= `NCA_RST_NIB;
    end else begin
      reg_wr_o <= exec && is_reg_form; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
      mem_wr_o <= exec && is_mem_form; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
      if (exec && is_alu) begin
        reg_col_o <= low_f;
        mem_row_o <= row_f;
        mem_col_field_o <= col_f;
        reg_wdata_o <= alu_res;
        mem_wdata_o <= alu_res;
      end
    end
  end

  // ----------------------------------------
  // Flags and pointer registers
  // ----------------------------------------
  logic compare_flag;
  logic [AR_W-1:0] address_pointer_reg;
  logic [IX_W-1:0] index_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      carry_flag <= 1'h0;
      compare_flag <= 1'h0;
      address_pointer_reg <= '0;
      index_reg <= '0;
    end else begin
      if (exec && is_arith) begin
        carry_flag <= alu_cout; // RQ2 RQ4
      end
      // A set from outside wins over the clear
      if (compare_set_i) begin
        compare_flag <= 1'h1;
      end else if (exec && (is_skt || is_skf)) begin
        compare_flag <= 1'h0; // RQ10 RQ11
      end
      if (exec && is_inc_ar) begin
        address_pointer_reg <= address_pointer_reg + 1'b1; // RQ8
      end
      if (exec && is_inc_ix) begin
        index_reg <= index_reg + 1'b1; // RQ9
      end
    end
  end

  assign carry_flag_o = carry_flag;
  assign compare_flag_o = compare_flag;
  assign address_pointer_reg_o = address_pointer_reg;
  assign index_reg_o = index_reg;

  // ----------------------------------------
  // Program counter and address fields
  // ----------------------------------------
  logic segment_bit;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      segment_bit <= `NCA_RST_SEG;
      page_o <= 2'h0;
      program_counter_o <= '0;
      branch_target_o <= 11'h000;
      entry_hi_o <= 3'h0;
      entry_lo_o <= 4'h0;
      periph_hi_o <= 3'h0;
      periph_lo_o <= 4'h0;
      regfile_row_o <= 3'h0;
      regfile_col_o <= 4'h0;
    end else begin
      if (segment_load_i) begin
        segment_bit <= segment_data_i; // RQ15
      end
      page_o <= pc_i[`NCA_PC_PAGE_HI:`NCA_PC_PAGE_LO]; // RQ14
      program_counter_o <= {segment_bit, pc_i[`NCA_PC_SEG-1:0]}; // RQ15
      if (instr_valid_i) begin
        branch_target_o <= instr_i[`NCA_TGT_HI:0]; // RQ16
        entry_hi_o <= row_f; // RQ17
        entry_lo_o <= low_f; // RQ17
        periph_hi_o <= row_f; // RQ18
        periph_lo_o <= low_f; // RQ18
        regfile_row_o <= row_f; // RQ19
        regfile_col_o <= low_f; // RQ19
      end
    end
  end

  assign segment_bit_o = segment_bit;

  // ----------------------------------------
  // Return-address stack
  // ----------------------------------------
  logic [STK_W-1:0] stack_mem [STK_DEPTH];
  logic [SP_W-1:0] stack_index;
  logic do_push;
  logic [STK_W-1:0] push_word;
  logic [SP_W-1:0] push_index;

  // Interrupt entry takes the push slot ahead of a program push
  assign do_push = irq_take_i || push_i;
  assign push_word = irq_take_i ? auto_saved_state_i : push_data_i; // RQ20
  assign push_index = stack_index - 1'b1;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      stack_mem[push_index] <= push_word; // RQ20 RQ21
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_index <= '0;
      stack_top_entry_o <= '0;
    end else begin
      if (do_push) begin
        stack_index <= push_index;
        stack_top_entry_o <= push_word;
      end else begin
        if (pop_i) begin
          stack_index <= stack_index + 1'b1;
        end
        stack_top_entry_o <= stack_mem[pop_i ? stack_index + 1'b1 : stack_index]; // RQ21
      end
    end
  end

  assign stack_index_o = stack_index;

endmodule

// ---- testbench/nca_mem_model.sv ----
// Register column and data memory model facing the execution unit
`timescale 1ns/1ps
module nca_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] instr_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_col_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic mem_wr_i,
  input wire logic [2:0] mem_row_i,
  input wire logic [3:0] mem_col_i,
  input wire logic [3:0] mem_wdata_i,
  output logic [3:0] reg_rdata_o,
  output logic [3:0] mem_rdata_o
);
  logic [3:0] regs [16];
  logic [3:0] mem [8][16];
  // Reads follow the fields of the word on the bus
  assign reg_rdata_o = regs[instr_i[3:0]];
  assign mem_rdata_o = mem[instr_i[10:8]][instr_i[7:4]];
  always @(posedge clk_i) begin
    if (reg_wr_i) regs[reg_col_i] <= reg_wdata_i;
    if (mem_wr_i) mem[mem_row_i][mem_col_i] <= mem_wdata_i;
  end
endmodule

// ---- testbench/nca_exec_monitor.sv ----
// Concurrent checks on the execution unit ports
`timescale 1ns/1ps
`include "nca_regs.svh"
module nca_exec_monitor
  import nca_pkg::*;
#(
  parameter int AR_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] reg_rdata_i,
  input wire logic [3:0] mem_rdata_i,
  input wire logic compare_set_i,
  input wire logic reg_wr_o,
  input wire logic [3:0] reg_col_o,
  input wire logic [3:0] reg_wdata_o,
  input wire logic mem_wr_o,
  input wire logic [3:0] mem_wdata_o,
  input wire logic skip_o,
  input wire logic nop_o,
  input wire logic carry_flag_o,
  input wire logic compare_flag_o,
  input wire logic [AR_W-1:0] address_pointer_reg_o
);
  logic pend;
  logic go;
  logic [4:0] op;
  assign op = instr_i[15:11];
  assign go = instr_valid_i && !skip_o && !pend;
  // Skip still owed across idle cycles
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend <= 1'b0;
    end else begin
      pend <= skip_o ? !instr_valid_i : (instr_valid_i ? 1'b0 : pend);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_skip_squash: assert property (
    instr_valid_i && (skip_o || pend) |=> nop_o && !reg_wr_o && !mem_wr_o)
    else $error("squashed instruction had an effect");
  a_equal_skip: assert property (
    go && op == `NCA_OP_SKE |=> !mem_wr_o && !reg_wr_o
      && skip_o == ($past(mem_rdata_i) == $past(instr_i[3:0])))
    else $error("equal compare skip wrong");
  a_unequal_skip: assert property (
    go && op == `NCA_OP_SKIP_IF_UNEQUAL |=> !mem_wr_o
      && skip_o == ($past(mem_rdata_i) != $past(instr_i[3:0])))
    else $error("unequal compare skip wrong");
  a_bits_set: assert property (
    go && op == `NCA_OP_SKT && !compare_set_i |=> !compare_flag_o
      && skip_o == (($past(mem_rdata_i) & $past(instr_i[3:0])) == $past(instr_i[3:0])))
    else $error("bits set test wrong");
  a_bits_clear: assert property (
    go && op == `NCA_OP_SKF && !compare_set_i |=> !compare_flag_o
      && skip_o == (($past(mem_rdata_i) & $past(instr_i[3:0])) == 4'h0))
    else $error("bits clear test wrong");
  a_add_reg: assert property (
    go && op == `NCA_OP_ADD_R |=> reg_wr_o && reg_col_o == $past(instr_i[3:0])
      && reg_wdata_o == 4'($past(reg_rdata_i) + $past(mem_rdata_i)))
    else $error("register add wrong");
  a_sub_mem: assert property (
    go && op == `NCA_OP_SUB_M |=> mem_wr_o && {carry_flag_o, mem_wdata_o}
      == 5'({1'b0, $past(mem_rdata_i)} - {1'b0, $past(instr_i[3:0])}))
    else $error("memory subtract wrong");
  a_inc_pointer: assert property (
    go && instr_i == 16'h3890 |=> address_pointer_reg_o == $past(address_pointer_reg_o) + 1'b1)
    else $error("address pointer increment wrong");
endmodule
bind nca_exec nca_exec_monitor #(.AR_W(AR_W)) u_mon (.clk_i, .rstn_i, .instr_valid_i,
  .instr_i, .reg_rdata_i, .mem_rdata_i, .compare_set_i, .reg_wr_o, .reg_col_o, .reg_wdata_o,
  .mem_wr_o, .mem_wdata_o, .skip_o, .nop_o, .carry_flag_o, .compare_flag_o,
  .address_pointer_reg_o);

// ---- testbench/nibble_core_alu_skip_decode_tb.sv ----
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module nibble_core_alu_skip_decode_tb;
  import nca_pkg::*;
  logic clk_i = 0, rstn_i = 0, instr_valid_i = 0, compare_set_i = 0, irq_take_i = 0;
  logic segment_load_i = 0, segment_data_i = 0, push_i = 0, pop_i = 0, exp_cy = 0;
  logic [15:0] instr_i = 0, auto_saved_state_i = 0, push_data_i = 0;
  logic [13:0] pc_i = 0;
  logic [3:0] reg_rdata_i, mem_rdata_i, reg_col_o, reg_wdata_o, mem_col_field_o, mem_wdata_o;
  logic [3:0] entry_lo_o, periph_lo_o, regfile_col_o;
  logic reg_wr_o, mem_wr_o, skip_o, nop_o, carry_flag_o, compare_flag_o, segment_bit_o;
  logic [2:0] mem_row_o, entry_hi_o, periph_hi_o, regfile_row_o, stack_index_o;
  logic [15:0] address_pointer_reg_o, stack_top_entry_o;
  logic [11:0] index_reg_o;
  logic [1:0] page_o;
  logic [13:0] program_counter_o;
  logic [10:0] branch_target_o;
  int n_fail = 0, n_compared = 0, cyc = 0;
  nca_exec dut (.clk_i, .rstn_i, .instr_valid_i, .instr_i, .reg_rdata_i, .mem_rdata_i,
    .compare_set_i, .pc_i, .segment_load_i, .segment_data_i, .irq_take_i, .auto_saved_state_i,
    .push_i, .push_data_i, .pop_i, .reg_wr_o, .reg_col_o, .reg_wdata_o, .mem_wr_o, .mem_row_o,
    .mem_col_field_o, .mem_wdata_o, .skip_o, .nop_o, .carry_flag_o, .compare_flag_o,
    .address_pointer_reg_o, .index_reg_o, .page_o, .segment_bit_o, .program_counter_o,
    .branch_target_o, .entry_hi_o, .entry_lo_o, .periph_hi_o, .periph_lo_o, .regfile_row_o,
    .regfile_col_o, .stack_top_entry_o, .stack_index_o);
  nca_mem_model mdl (.clk_i, .instr_i, .reg_wr_i(reg_wr_o), .reg_col_i(reg_col_o),
    .reg_wdata_i(reg_wdata_o), .mem_wr_i(mem_wr_o), .mem_row_i(mem_row_o),
    .mem_col_i(mem_col_field_o), .mem_wdata_i(mem_wdata_o), .reg_rdata_o(reg_rdata_i),
    .mem_rdata_o(mem_rdata_i));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic issue(input logic [15:0] w);
    step();
    instr_i = w;
    instr_valid_i = 1;
    step();
    instr_valid_i = 0;
  endtask
  task automatic t_inc();
    issue(16'h3890);
    issue(16'h3890);
    issue(16'h3891);
    issue(16'h3880);
    issue(16'h3980);
    `CHK(address_pointer_reg_o, 16'h0002)
    `CHK(index_reg_o, 12'h001)
    $display("increment test done");
  endtask
  task automatic t_alu();
    logic [3:0] a, b;
    logic [4:0] r, op;
    logic mf;
    for (int i = 0; i < 14; i++) begin
      mf = i > 6;
      op = {mf, 1'b0, 3'(i % 7)};
      a = mf ? mdl.mem[2][i] : mdl.regs[4'(i + 1)];
      b = mf ? 4'(i * 3 + 5) : mdl.mem[2][i];
      case (i % 7)
        0: r = a + b;
        1: r = a - b;
        2: r = a + b + exp_cy;
        3: r = a - b - exp_cy;
        4: r = {1'b0, a & b};
        5: r = {1'b0, a ^ b};
        default: r = {1'b0, a | b};
      endcase
      issue({op, 3'h2, 4'(i), mf ? b : 4'(i + 1)});
      `CHK(mf ? mem_wr_o : reg_wr_o, 1'b1)
      `CHK(mf ? mem_wdata_o : reg_wdata_o, r[3:0])
      `CHK({mem_row_o, mem_col_field_o}, {3'h2, 4'(i)})
      `CHK(reg_col_o, mf ? b : 4'(i + 1))
      if (i % 7 < 4) begin
        exp_cy = r[4];
        `CHK(carry_flag_o, exp_cy)
      end
    end
    $display("alu test done");
  endtask
  task automatic t_skip(input logic [4:0] op, input logic [3:0] m, n, input logic hit);
    mdl.mem[1][5] = m;
    step();
    compare_set_i = 1;
    step();
    compare_set_i = 0;
    instr_i = {op, 3'h1, 4'h5, n};
    instr_valid_i = 1;
    step();
    instr_i = 16'h0131;
    `CHK(skip_o, hit)
    `CHK(compare_flag_o, op[4:1] != 4'hf)
    step();
    instr_valid_i = 0;
    `CHK(nop_o, hit)
    `CHK(reg_wr_o, !hit)
    $display("skip test done");
  endtask
  task automatic t_fields();
    step();
    pc_i = 14'h1abc;
    segment_load_i = 1;
    segment_data_i = 1;
    issue(16'h65a3);
    segment_load_i = 0;
    `CHK(page_o, 2'h3)
    `CHK(segment_bit_o, 1'b1)
    `CHK(program_counter_o, 14'h3abc)
    `CHK(branch_target_o, 11'h5a3)
    `CHK({entry_hi_o, entry_lo_o, periph_hi_o, periph_lo_o}, {2{7'h53}})
    `CHK({regfile_row_o, regfile_col_o}, 7'h53)
    $display("field test done");
  endtask
  task automatic t_stack();
    step();
    irq_take_i = 1;
    auto_saved_state_i = 16'hbeef;
    push_i = 1;
    push_data_i = 16'h1234;
    step();
    irq_take_i = 0;
    push_data_i = 16'h5678;
    `CHK({stack_index_o, stack_top_entry_o}, {3'h7, 16'hbeef})
    step();
    push_i = 0;
    pop_i = 1;
    `CHK({stack_index_o, stack_top_entry_o}, {3'h6, 16'h5678})
    step();
    pop_i = 0;
    `CHK({stack_index_o, stack_top_entry_o}, {3'h7, 16'hbeef})
    $display("stack test done");
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      mdl.regs[i] = 4'(i * 5 + 3);
      for (int r = 0; r < 8; r++) mdl.mem[r][i] = 4'(r + i * 7);
    end
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1;
    t_inc();
    t_alu();
    t_skip(5'h09, 4'h6, 4'h6, 1);
    t_skip(5'h09, 4'h6, 4'h7, 0);
    t_skip(5'h0b, 4'h6, 4'h7, 1);
    t_skip(5'h0b, 4'h6, 4'h6, 0);
    t_skip(5'h1e, 4'hb, 4'h3, 1);
    t_skip(5'h1e, 4'hb, 4'h4, 0);
    t_skip(5'h1f, 4'ha, 4'h5, 1);
    t_skip(5'h1f, 4'ha, 4'h3, 0);
    t_fields();
    t_stack();
    end_of_test();
  end
endmodule
